/* File: sbc_ctrl.sv */
/*
  controller end: drives one strobe-encoded command per request.
  assumes the user keeps legal spacing; only refresh, mode load and precharge-all waits are enforced here.
*/
`timescale 1ns/100ps
`include "sbc_map.svh"
module sbc_ctrl #(
  parameter int PRECHARGE_TIME  = `SBC_CYC(`SBC_PRECHARGE_PS),
  parameter int REFRESH_CYCLE_TIME = `SBC_CYC(`SBC_REFRESH_CYCLE_PS),
  parameter int MODE_LOAD_TIME = `SBC_CYC(`SBC_MODE_LOAD_PS)
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  // user request
  input  wire logic                   req_valid,
  input  wire sbc_pkg::sbc_cmd_t      req_cmd,
  input  wire logic                   req_refresh,
  input  wire logic                   req_mode_load,
  input  wire logic [1:0]             req_bank,
  input  wire logic [`SBC_ROW_W-1:0]  req_addr,
  input  wire logic                   req_cke,
  output logic                        req_ready,
  // link
  sbc_if.ctrl                         link
);
  localparam int CW = 8;
  initial begin
    if (PRECHARGE_TIME < 1 || REFRESH_CYCLE_TIME < 1 || MODE_LOAD_TIME < 1 || PRECHARGE_TIME > 255 || REFRESH_CYCLE_TIME > 255 || MODE_LOAD_TIME > 255)
      $error("sbc_ctrl: timing parameter out of range");
  end

  logic [CW-1:0] hold_r;
  logic [3:0]    strobes_nxt;

  // cs, ras, cas, we (active low)
  always_comb begin
    strobes_nxt = 4'hF;
    if (req_refresh)        strobes_nxt = 4'h1;
    else if (req_mode_load) strobes_nxt = 4'h0;
    else begin
      case (req_cmd)
        sbc_pkg::SBC_CMD_NOP:   strobes_nxt = 4'h7;
        sbc_pkg::SBC_CMD_ACT:   strobes_nxt = 4'h3;
        sbc_pkg::SBC_CMD_READ:  strobes_nxt = 4'h5;
        sbc_pkg::SBC_CMD_WRITE: strobes_nxt = 4'h4;
        sbc_pkg::SBC_CMD_PRE:   strobes_nxt = 4'h2;
        sbc_pkg::SBC_CMD_BST:   strobes_nxt = 4'h6;
        default:                strobes_nxt = 4'hF;
      endcase
    end
  end

  wire take = req_valid && (hold_r == '0);
  wire [CW-1:0] wait_nxt = req_refresh   ? CW'(REFRESH_CYCLE_TIME) :
                           req_mode_load ? CW'(MODE_LOAD_TIME) :
                           (req_cmd == sbc_pkg::SBC_CMD_PRE && req_addr[`SBC_AUTO_PRE_BIT])
                                         ? CW'(PRECHARGE_TIME) : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {link.chip_select_n, link.row_strobe_n, link.column_strobe_n, link.write_enable_n} <= 4'hF;
      link.bank_addr    <= 2'h0;
      link.addr         <= '0;
      link.clock_enable <= 1'b1;
      hold_r            <= '0;
      req_ready         <= 1'b0;
    end else begin
      link.clock_enable <= req_cke;
      req_ready         <= (hold_r <= CW'(1)) && !take;
      if (take) begin
        // busy all-bank states are held off here
        {link.chip_select_n, link.row_strobe_n, link.column_strobe_n, link.write_enable_n}
          <= strobes_nxt;
        link.bank_addr <= req_bank;
        link.addr      <= req_addr;
        hold_r         <= wait_nxt;
      end else begin
        {link.chip_select_n, link.row_strobe_n, link.column_strobe_n, link.write_enable_n} <= 4'h7;
        if (hold_r != '0) hold_r <= hold_r - CW'(1);
      end
    end
  end
endmodule

/* File: sbc_device.sv */
/*
  per-bank command decode and state tracking for a four-bank sdram device.
  assumes a controller on the same clock driving legal command sequences.
*/
// Function
// - chip select high: deselect, work continues
// - nop leaves ongoing operations unchanged
// - activate on idle bank opens row
// - refresh, mode load only when all idle
// - refresh busy for refresh_cycle_time, then idle
// - mode load busy for mode_load_time, then idle
// - only deselect/nop during all-bank busy states
// - precharge of idle bank is nop
// - read/write in row active starts burst
// - precharge closes one bank or all
// - precharge truncates plain read burst
// - precharge truncates plain write burst
// - burst stop ends newest burst, any bank
// - read burst accepts new read or write
// - write burst accepts new write or read
// - precharging lasts precharge_time, then idle
// - busy bank gets only nop or other-bank commands
// - activating lasts activate_to_column_time, then active
// - auto precharge busy until precharge_time after burst
// - decode only with clock enable high twice, post exit
// - controller issues only defined combinations
// - precharge-all idles every bank after precharge_time
// - burst stop with enable falling, idle: deep power-down
`timescale 1ns/100ps
`include "sbc_map.svh"
module sbc_device #(
  parameter int PRECHARGE_TIME   = `SBC_CYC(`SBC_PRECHARGE_PS),
  parameter int ACTIVATE_TO_COLUMN_TIME  = `SBC_CYC(`SBC_ACT_TO_COL_PS),
  parameter int REFRESH_CYCLE_TIME  = `SBC_CYC(`SBC_REFRESH_CYCLE_PS),
  parameter int MODE_LOAD_TIME  = `SBC_CYC(`SBC_MODE_LOAD_PS),
  parameter int SELF_REFRESH_EXIT_TIME  = `SBC_CYC(`SBC_SR_EXIT_PS),
  parameter int BURST = `SBC_BURST_LEN
) (
  // clock and reset
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  // link
  sbc_if.dev                                link,
  // user side: per-bank state and open rows
  output logic [4*`SBC_NUM_BANKS-1:0]       bank_state,
  output logic [`SBC_NUM_BANKS-1:0]         bank_idle,
  output logic [`SBC_NUM_BANKS*`SBC_ROW_W-1:0] open_row,
  output logic                              deep_power_down,
  output logic                              all_idle,
  // self refresh exit notice, starts the exit wait
  input  wire logic                         self_refresh_exit
);
  localparam int NB = `SBC_NUM_BANKS;
  localparam int CW = 8;

  initial begin
    if (PRECHARGE_TIME < 1 || ACTIVATE_TO_COLUMN_TIME < 1 || REFRESH_CYCLE_TIME < 1 || MODE_LOAD_TIME < 1 || BURST < 1 || SELF_REFRESH_EXIT_TIME < 1 ||
        REFRESH_CYCLE_TIME > 255 || PRECHARGE_TIME > 255 || ACTIVATE_TO_COLUMN_TIME > 255 || MODE_LOAD_TIME > 255 || BURST > 255 || SELF_REFRESH_EXIT_TIME > 255)
      $error("sbc_device: timing parameter out of range");
  end

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction

  sbc_pkg::sbc_state_t st_r   [NB];
  sbc_pkg::sbc_state_t st_nxt [NB];
  logic [CW-1:0]       cnt_r  [NB];
  logic [CW-1:0]       cnt_nxt[NB];
  logic [`SBC_ROW_W-1:0] row_r[NB];
  logic                cke_prev_r;
  logic [CW-1:0]       xsr_r;
  logic [1:0]          last_bank_r;
  logic                dpd_r;

  wire cs  = ~link.chip_select_n;
  wire ras = ~link.row_strobe_n;
  wire cas = ~link.column_strobe_n;
  wire we  = ~link.write_enable_n;
  wire ap  = link.addr[`SBC_AUTO_PRE_BIT];
  wire [1:0] ba = link.bank_addr;

  wire sbc_pkg::sbc_cmd_t cmd =
    !cs                 ? sbc_pkg::SBC_CMD_DESEL :
    (!ras && !cas && !we) ? sbc_pkg::SBC_CMD_NOP :
    ( ras && !cas && !we) ? sbc_pkg::SBC_CMD_ACT :
    (!ras &&  cas && !we) ? sbc_pkg::SBC_CMD_READ :
    (!ras &&  cas &&  we) ? sbc_pkg::SBC_CMD_WRITE :
    ( ras && !cas &&  we) ? sbc_pkg::SBC_CMD_PRE :
    (!ras && !cas &&  we) ? sbc_pkg::SBC_CMD_BST : sbc_pkg::SBC_CMD_RSVD;
  wire is_ref  = cs && ras && cas && !we;
  wire is_mrs  = cs && ras && cas && we;

  // decode gate: enable high twice, exit wait over
  wire decode_en = cke_prev_r && link.clock_enable && (xsr_r == '0) && !dpd_r;
  wire dpd_entry = cke_prev_r && !link.clock_enable && cs && !ras && !cas && we;

  logic all_idle_w;
  always_comb begin
    all_idle_w = 1'b1;
    for (int i = 0; i < NB; i++)
      if (st_r[i] != sbc_pkg::SBC_ST_IDLE) all_idle_w = 1'b0;
  end

  always_comb begin
    for (int i = 0; i < NB; i++) begin
      logic hit;
      logic cnt_done;
      hit        = decode_en && (ba == 2'(i));
      cnt_done   = (cnt_r[i] <= cyc(1));
      st_nxt[i]  = st_r[i];
      cnt_nxt[i] = (cnt_r[i] != '0) ? cnt_r[i] - cyc(1) : cnt_r[i];
      case (st_r[i])
        sbc_pkg::SBC_ST_IDLE: begin
          if (hit && cmd == sbc_pkg::SBC_CMD_ACT) begin
            st_nxt[i]  = sbc_pkg::SBC_ST_ACTIVATING;
            cnt_nxt[i] = cyc(ACTIVATE_TO_COLUMN_TIME);
          end else if (decode_en && is_ref && all_idle_w) begin
            st_nxt[i]  = sbc_pkg::SBC_ST_REFRESHING;
            cnt_nxt[i] = cyc(REFRESH_CYCLE_TIME);
          end else if (decode_en && is_mrs && all_idle_w) begin
            st_nxt[i]  = sbc_pkg::SBC_ST_MODE_LOAD;
            cnt_nxt[i] = cyc(MODE_LOAD_TIME);
          end else if (dpd_entry && all_idle_w) begin
            st_nxt[i]  = sbc_pkg::SBC_ST_DEEP_PD;
          end
          // precharge to an idle bank falls through unchanged
        end
        sbc_pkg::SBC_ST_ACTIVATING:
          if (cnt_done) st_nxt[i] = sbc_pkg::SBC_ST_ACTIVE;
        sbc_pkg::SBC_ST_ACTIVE, sbc_pkg::SBC_ST_READ, sbc_pkg::SBC_ST_WRITE: begin
          if (decode_en && cmd == sbc_pkg::SBC_CMD_PRE && (hit || ap)) begin
            st_nxt[i]  = ap ? sbc_pkg::SBC_ST_PRE_ALL
                            : sbc_pkg::SBC_ST_PRECHARGING;
            cnt_nxt[i] = cyc(PRECHARGE_TIME);
          end else if (hit && (cmd == sbc_pkg::SBC_CMD_READ ||
                               cmd == sbc_pkg::SBC_CMD_WRITE)) begin
            if (cmd == sbc_pkg::SBC_CMD_READ)
              st_nxt[i] = ap ? sbc_pkg::SBC_ST_READ_AP : sbc_pkg::SBC_ST_READ;
            else
              st_nxt[i] = ap ? sbc_pkg::SBC_ST_WRITE_AP : sbc_pkg::SBC_ST_WRITE;
            cnt_nxt[i] = ap ? cyc(BURST + PRECHARGE_TIME) : cyc(BURST);
          end else if (decode_en && cmd == sbc_pkg::SBC_CMD_BST &&
                       last_bank_r == 2'(i) && st_r[i] != sbc_pkg::SBC_ST_ACTIVE) begin
            st_nxt[i] = sbc_pkg::SBC_ST_ACTIVE;
          end else if (st_r[i] != sbc_pkg::SBC_ST_ACTIVE && cnt_done) begin
            st_nxt[i] = sbc_pkg::SBC_ST_ACTIVE;
          end
        end
        sbc_pkg::SBC_ST_READ_AP, sbc_pkg::SBC_ST_WRITE_AP,
        sbc_pkg::SBC_ST_PRECHARGING, sbc_pkg::SBC_ST_PRE_ALL:
          if (cnt_done) st_nxt[i] = sbc_pkg::SBC_ST_IDLE;
        sbc_pkg::SBC_ST_REFRESHING, sbc_pkg::SBC_ST_MODE_LOAD:
          if (cnt_done) st_nxt[i] = sbc_pkg::SBC_ST_IDLE;
        sbc_pkg::SBC_ST_DEEP_PD:
          if (link.clock_enable) st_nxt[i] = sbc_pkg::SBC_ST_IDLE;
        default: st_nxt[i] = sbc_pkg::SBC_ST_IDLE;
      endcase
    end
  end

  wire burst_start = decode_en && (cmd == sbc_pkg::SBC_CMD_READ || cmd == sbc_pkg::SBC_CMD_WRITE);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < NB; i++) begin
        st_r[i]  <= sbc_pkg::SBC_ST_IDLE;
        cnt_r[i] <= '0;
        row_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NB; i++) begin
        st_r[i]  <= st_nxt[i];
        cnt_r[i] <= cnt_nxt[i];
        if (st_r[i] == sbc_pkg::SBC_ST_IDLE && st_nxt[i] == sbc_pkg::SBC_ST_ACTIVATING)
          row_r[i] <= link.addr;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cke_prev_r  <= 1'b0;
      xsr_r       <= '0;
      last_bank_r <= 2'h0;
      dpd_r       <= 1'b0;
    end else begin
      cke_prev_r <= link.clock_enable;
      if (self_refresh_exit) xsr_r <= cyc(SELF_REFRESH_EXIT_TIME);
      else if (xsr_r != '0) xsr_r <= xsr_r - cyc(1);
      if (burst_start) last_bank_r <= ba;
      dpd_r <= (st_nxt[0] == sbc_pkg::SBC_ST_DEEP_PD);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bank_state      <= '0;
      bank_idle       <= '1;
      open_row        <= '0;
      deep_power_down <= 1'b0;
      all_idle        <= 1'b1;
    end else begin
      for (int i = 0; i < NB; i++) begin
        bank_state[4*i +: 4]                  <= st_nxt[i];
        bank_idle[i]                          <= (st_nxt[i] == sbc_pkg::SBC_ST_IDLE);
        open_row[`SBC_ROW_W*i +: `SBC_ROW_W]  <= row_r[i];
      end
      deep_power_down <= (st_nxt[0] == sbc_pkg::SBC_ST_DEEP_PD);
      all_idle        <= (st_nxt[0] == sbc_pkg::SBC_ST_IDLE) && (st_nxt[1] == sbc_pkg::SBC_ST_IDLE)
                      && (st_nxt[2] == sbc_pkg::SBC_ST_IDLE) && (st_nxt[3] == sbc_pkg::SBC_ST_IDLE);
    end
  end
endmodule

/* File: sbc_if.sv */
/*
  strobe-encoded command link between controller and memory device.
  assumes one shared clock; all signals sampled on its rising edge.
*/
`timescale 1ns/100ps
`include "sbc_map.svh"
interface sbc_if;
  logic                         clock_enable;
  logic                         chip_select_n;
  logic                         row_strobe_n;
  logic                         column_strobe_n;
  logic                         write_enable_n;
  logic [1:0]                   bank_addr;
  logic [`SBC_ROW_W-1:0]        addr;
  modport ctrl (output clock_enable, chip_select_n, row_strobe_n, column_strobe_n,
                output write_enable_n, bank_addr, addr);
  modport dev  (input clock_enable, chip_select_n, row_strobe_n, column_strobe_n,
                input write_enable_n, bank_addr, addr);
endinterface

/* File: sbc_map.svh */
/*
  timing counts and field positions for the bank command tracker.
  assumes a 40 MHz clock; counts are whole cycles rounded up.
*/
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_CLK_PERIOD_PS      25000
`define SBC_PRECHARGE_PS       19200
`define SBC_ACT_TO_COL_PS      19200
`define SBC_REFRESH_CYCLE_PS   80000
`define SBC_MODE_LOAD_PS       15000
`define SBC_SR_EXIT_PS         120000
`define SBC_CYC(ps)            (((ps) + `SBC_CLK_PERIOD_PS - 1) / `SBC_CLK_PERIOD_PS)
`define SBC_BURST_LEN          4
`define SBC_AUTO_PRE_BIT       10
`define SBC_NUM_BANKS          4
`define SBC_ROW_W              12
`define SBC_COL_W              8
`endif

/* File: sbc_monitor.sv */
/*
  concurrent checks on the command link and the device's bank states.
  assumes the testbench instantiates it beside the link, default timing counts.
*/
`timescale 1ns/100ps
`include "sbc_map.svh"
module sbc_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        arst_n,
  // link
  input wire logic        clock_enable,
  input wire logic        chip_select_n,
  input wire logic        row_strobe_n,
  input wire logic        column_strobe_n,
  input wire logic        write_enable_n,
  input wire logic [1:0]  bank_addr,
  input wire logic [11:0] addr,
  // device state
  input wire logic [15:0] bank_state,
  input wire logic [3:0]  bank_idle,
  input wire logic        all_idle,
  input wire logic        deep_power_down,
  // self refresh exit notice, starts the exit wait
  input wire logic        self_refresh_exit
);
  logic [7:0] xsr_r;
  logic       cke_q_r;
  logic       ap_q_r;
  logic [1:0] ba_q_r;
  logic [1:0] last_r;
  // commands count only with enable high twice and the exit wait over
  wire ok    = clock_enable & cke_q_r & (xsr_r == 8'h00);
  wire cs    = ~chip_select_n;
  wire c_bst = cs & row_strobe_n & column_strobe_n & ~write_enable_n;
  wire act   = ok & cs & ~row_strobe_n & column_strobe_n & write_enable_n;
  wire rd    = ok & cs & row_strobe_n & ~column_strobe_n & write_enable_n;
  wire wr    = ok & cs & row_strobe_n & ~column_strobe_n & ~write_enable_n;
  wire pre   = ok & cs & ~row_strobe_n & column_strobe_n & ~write_enable_n;
  wire rfs   = ok & cs & ~row_strobe_n & ~column_strobe_n & write_enable_n;
  wire mrs   = ok & cs & ~row_strobe_n & ~column_strobe_n & ~write_enable_n;
  wire exe   = cs & ~(row_strobe_n & column_strobe_n & write_enable_n);
  wire [3:0] cur = bank_state[4*bank_addr +: 4];
  wire [3:0] nxt = bank_state[4*ba_q_r +: 4];
  wire [3:0] lst = bank_state[4*last_r +: 4];
  // remembers addressed bank and auto precharge bit of the last edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cke_q_r <= 1'b0;
      ap_q_r  <= 1'b0;
      ba_q_r  <= 2'h0;
      last_r  <= 2'h0;
      xsr_r   <= 8'h00;
    end else begin
      cke_q_r <= clock_enable;
      if (self_refresh_exit) xsr_r <= 8'(`SBC_CYC(`SBC_SR_EXIT_PS));
      else if (xsr_r != 8'h00) xsr_r <= xsr_r - 8'h01;
      ap_q_r  <= addr[10];
      ba_q_r  <= bank_addr;
      last_r  <= (rd | wr) ? bank_addr : last_r;
    end
  end
  default clocking dcb @(posedge clk); endclocking
  default disable iff (!arst_n);
  act_opens_a: assert property (act && cur == sbc_pkg::SBC_ST_IDLE |=>
    nxt == sbc_pkg::SBC_ST_ACTIVATING) else $error("activate did not open row");
  idle_pre_nop_a: assert property (pre && !addr[10] && cur == sbc_pkg::SBC_ST_IDLE |=>
    nxt == sbc_pkg::SBC_ST_IDLE) else $error("precharge changed idle bank");
  pre_closes_a: assert property (pre && !addr[10] && cur inside {sbc_pkg::SBC_ST_ACTIVE,
    sbc_pkg::SBC_ST_READ, sbc_pkg::SBC_ST_WRITE} |=> nxt == sbc_pkg::SBC_ST_PRECHARGING)
    else $error("precharge did not start");
  read_burst_a: assert property (rd && cur inside {sbc_pkg::SBC_ST_ACTIVE,
    sbc_pkg::SBC_ST_READ, sbc_pkg::SBC_ST_WRITE} |=> nxt == (ap_q_r ?
    sbc_pkg::SBC_ST_READ_AP : sbc_pkg::SBC_ST_READ)) else $error("read burst not started");
  write_burst_a: assert property (wr && cur inside {sbc_pkg::SBC_ST_ACTIVE,
    sbc_pkg::SBC_ST_READ, sbc_pkg::SBC_ST_WRITE} |=> nxt == (ap_q_r ?
    sbc_pkg::SBC_ST_WRITE_AP : sbc_pkg::SBC_ST_WRITE)) else $error("write burst not started");
  nop_holds_a: assert property (!exe && cur == sbc_pkg::SBC_ST_ACTIVE |=>
    nxt == sbc_pkg::SBC_ST_ACTIVE) else $error("idle cycle changed active bank");
  refresh_busy_a: assert property (rfs |=> !all_idle [*4] ##1 all_idle)
    else $error("refresh length wrong");
  mode_busy_a: assert property (mrs |=> !all_idle ##1 all_idle)
    else $error("mode load length wrong");
  busy_quiet_a: assert property (rfs |=> !exe [*4])
    else $error("command during refresh");
  bst_ends_a: assert property (ok && c_bst && lst inside {sbc_pkg::SBC_ST_READ,
    sbc_pkg::SBC_ST_WRITE} |=> lst == sbc_pkg::SBC_ST_ACTIVE) else $error("burst not ended");
  dpd_entry_a: assert property (!clock_enable && cke_q_r && c_bst && all_idle
    |=> deep_power_down) else $error("deep power-down not entered");
  pre_all_a: assert property (pre && addr[10] |=> ##1 bank_idle == 4'hF)
    else $error("precharge all left a bank open");
  idle_only_a: assert property (rfs || mrs |-> all_idle)
    else $error("refresh or mode load with bank open");
  cover property (act);
  cover property (rfs);
  cover property (!clock_enable && cke_q_r && c_bst && all_idle);
endmodule

/* File: sbc_pkg.sv */
/*
  types for the bank command tracker.
  assumes sbc_map.svh for all numbers.
*/
package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_CMD_DESEL, SBC_CMD_NOP, SBC_CMD_ACT, SBC_CMD_READ,
    SBC_CMD_WRITE, SBC_CMD_PRE, SBC_CMD_BST, SBC_CMD_RSVD
  } sbc_cmd_t;
  typedef enum logic [3:0] {
    SBC_ST_IDLE, SBC_ST_ACTIVATING, SBC_ST_ACTIVE, SBC_ST_READ, SBC_ST_WRITE,
    SBC_ST_READ_AP, SBC_ST_WRITE_AP, SBC_ST_PRECHARGING, SBC_ST_REFRESHING,
    SBC_ST_MODE_LOAD, SBC_ST_PRE_ALL, SBC_ST_DEEP_PD
  } sbc_state_t;
endpackage

/* File: testbench.sv */
/*
  self-checking bench: controller and device joined by the link.
  assumes default timing counts of both ends and the monitor beside the link.
*/
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [1:0] b; logic [3:0] s; logic [11:0] r;} sbc_exp_t;
  logic clk, arst_n, rv, rr, rm, cke, rdy, sre, dpd, ai, watch;
  logic [1:0] rb, b;
  logic [11:0] ra, r;
  logic [15:0] bs, prev;
  logic [3:0] bi;
  logic [47:0] orow;
  logic [31:0] seed;
  sbc_pkg::sbc_cmd_t rc;
  sbc_exp_t q[$];
  sbc_exp_t e;
  int err_count, compares, cyc;
  sbc_if lnk();
  sbc_ctrl sbc_ctrl_i (.clk(clk), .arst_n(arst_n), .req_valid(rv), .req_cmd(rc),
    .req_refresh(rr), .req_mode_load(rm), .req_bank(rb), .req_addr(ra), .req_cke(cke),
    .req_ready(rdy), .link(lnk));
  sbc_device sbc_device_i (.clk(clk), .arst_n(arst_n), .link(lnk), .bank_state(bs),
    .bank_idle(bi), .open_row(orow), .deep_power_down(dpd), .all_idle(ai),
    .self_refresh_exit(sre));
  sbc_monitor sbc_monitor_i (.clk(clk), .arst_n(arst_n), .clock_enable(lnk.clock_enable),
    .chip_select_n(lnk.chip_select_n), .row_strobe_n(lnk.row_strobe_n),
    .column_strobe_n(lnk.column_strobe_n), .write_enable_n(lnk.write_enable_n),
    .bank_addr(lnk.bank_addr), .addr(lnk.addr), .bank_state(bs), .bank_idle(bi),
    .all_idle(ai), .deep_power_down(dpd), .self_refresh_exit(sre));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(logic [63:0] seen, logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic ex(logic [1:0] bk, sbc_pkg::sbc_state_t s, logic [11:0] row = 12'h0);
    q.push_back({bk, s, row});
  endtask
  // one request, issued once the controller is ready or after 100 cycles of waiting
  task automatic rq(sbc_pkg::sbc_cmd_t c, logic [1:0] bk, logic [11:0] a,
                    logic [1:0] ov = 2'h0, logic k = 1'b1);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    @(posedge clk);
    rv <= 1'b1;
    rc <= c;
    rb <= bk;
    ra <= a;
    rr <= ov[1];
    rm <= ov[0];
    cke <= k;
    @(posedge clk);
    rv <= 1'b0;
    rr <= 1'b0;
    rm <= 1'b0;
  endtask
  task automatic w(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic summarize();
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // while watch is set, each bank state change is matched against the oldest note
  always @(negedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if (watch && arst_n && bs[4*i +: 4] !== prev[4*i +: 4]) begin
        e = (q.size() > 0) ? q.pop_front() : '1;
        chk({2'(i), bs[4*i +: 4], (bs[4*i +: 4] == sbc_pkg::SBC_ST_ACTIVE ?
          orow[12*i +: 12] : 12'h0)}, e);
      end
    end
    prev <= bs;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      summarize();
    end
  end
  initial begin
    {arst_n, rv, rr, rm, sre, prev, ra, rb, err_count, compares, cyc} = '0;
    {cke, watch} = 2'b11;
    rc = sbc_pkg::SBC_CMD_NOP;
    seed = 32'h0000629F;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk) sre <= 1'b1;
    @(posedge clk) sre <= 1'b0;
    rq(sbc_pkg::SBC_CMD_ACT, 2'h2, 12'h0);
    w(8);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      b = seed[1:0];
      r = seed[13:2];
      ex(b, sbc_pkg::SBC_ST_ACTIVATING);
      ex(b, sbc_pkg::SBC_ST_ACTIVE, r);
      rq(sbc_pkg::SBC_CMD_ACT, b, r);
      w(4);
      case (k)
        0: begin
          rq(sbc_pkg::SBC_CMD_PRE, b ^ 2'h1, 12'h0);
          ex(b, sbc_pkg::SBC_ST_READ);
          ex(b, sbc_pkg::SBC_ST_WRITE);
          ex(b, sbc_pkg::SBC_ST_ACTIVE, r);
          rq(sbc_pkg::SBC_CMD_READ, b, 12'h0);
          rq(sbc_pkg::SBC_CMD_WRITE, b, 12'h0);
        end
        1: begin
          ex(b, sbc_pkg::SBC_ST_WRITE);
          ex(b, sbc_pkg::SBC_ST_READ);
          ex(b, sbc_pkg::SBC_ST_ACTIVE, r);
          rq(sbc_pkg::SBC_CMD_WRITE, b, 12'h0);
          rq(sbc_pkg::SBC_CMD_READ, b, 12'h0);
        end
        2: begin
          ex(b, sbc_pkg::SBC_ST_READ);
          ex(b, sbc_pkg::SBC_ST_ACTIVE, r);
          rq(sbc_pkg::SBC_CMD_READ, b, 12'h0);
          rq(sbc_pkg::SBC_CMD_BST, b, 12'h0);
        end
        default: begin
          ex(b, sbc_pkg::SBC_ST_READ_AP);
          ex(b, sbc_pkg::SBC_ST_IDLE);
          rq(sbc_pkg::SBC_CMD_READ, b, 12'h400);
          w(10);
          ex(b, sbc_pkg::SBC_ST_ACTIVATING);
          ex(b, sbc_pkg::SBC_ST_ACTIVE, r);
          rq(sbc_pkg::SBC_CMD_ACT, b, r);
          w(4);
        end
      endcase
      w(8);
      ex(b, k[1] ? sbc_pkg::SBC_ST_READ : sbc_pkg::SBC_ST_WRITE);
      if (k != 3) begin
        ex(b, sbc_pkg::SBC_ST_PRECHARGING);
        rq(k[1] ? sbc_pkg::SBC_CMD_READ : sbc_pkg::SBC_CMD_WRITE, b, 12'h0);
      end
      else begin
        q[q.size()-1].s = sbc_pkg::SBC_ST_WRITE_AP;
        rq(sbc_pkg::SBC_CMD_WRITE, b, 12'h400);
      end
      ex(b, sbc_pkg::SBC_ST_IDLE);
      if (k != 3)
        rq(sbc_pkg::SBC_CMD_PRE, b, 12'h0);
      w(12);
    end
    chk(q.size(), 0);
    watch = 1'b0;
    rq(sbc_pkg::SBC_CMD_ACT, 2'h1, 12'h0);
    w(4);
    rq(sbc_pkg::SBC_CMD_PRE, 2'h0, 12'h400);
    w(4);
    chk(bi, 4'hF);
    rq(sbc_pkg::SBC_CMD_NOP, 2'h0, 12'h0, 2'b10);
    w(2);
    chk(ai, 1'b0);
    w(8);
    chk(ai, 1'b1);
    rq(sbc_pkg::SBC_CMD_NOP, 2'h0, 12'h0, 2'b01);
    w(6);
    chk(ai, 1'b1);
    rq(sbc_pkg::SBC_CMD_BST, 2'h0, 12'h0, 2'b00, 1'b0);
    w(3);
    chk(dpd, 1'b1);
    cke <= 1'b1;
    w(4);
    chk(dpd, 1'b0);
    summarize();
  end
endmodule
